// ### mrd_decoder.sv
// decoder end: envelope sampling, raw pass-through and manchester recovery
`timescale 1ns/1ps

module mrd_decoder (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [16:0] sclk_div,
  input  wire logic        manch_en,
  output logic             locked,
  mrd_link_if.dev          link
);

  typedef struct packed {
    logic                env_s1;
    logic                env_s2;
    logic [16:0]         div_cnt;
    logic                tick;
    logic                samp;
    logic [3:0]          gap;
    logic                mid_phase;
    mrd_pkg::mrd_state_t state;
    logic [3:0]          pre_cnt;
    logic                data;
    logic                strobe;
    logic [2:0]          strb_cnt;
    logic                locked;
  } mrd_dev_st_t;

  mrd_dev_st_t st_r;
  mrd_dev_st_t st_nxt;

  logic [16:0] div_lim;
  logic [3:0]  ivl;
  logic        edge_seen;
  logic        is_long;
  logic        is_short;
  logic        emit;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    emit   = 1'b0;
    // out-of-range settings are clamped, not trusted
    if (sclk_div < mrd_pkg::DIV_MIN) begin
      div_lim = mrd_pkg::DIV_MIN;
    end else if (sclk_div > mrd_pkg::DIV_MAX) begin
      div_lim = mrd_pkg::DIV_MAX;
    end else begin
      div_lim = sclk_div;
    end
    edge_seen = st_r.env_s2 != st_r.samp;
    ivl       = (st_r.gap == mrd_pkg::GAP_SAT) ? st_r.gap : st_r.gap + 4'h1;
    is_long   = (ivl >= mrd_pkg::LONG_MIN) && (ivl <= mrd_pkg::LONG_MAX);
    is_short  = (ivl >= mrd_pkg::SHORT_MIN) && (ivl <= mrd_pkg::SHORT_MAX);

    st_nxt.env_s1 = link.envelope_in;
    st_nxt.env_s2 = st_r.env_s1;

    // sample tick divider
    if (st_r.div_cnt + 17'h0_0001 >= div_lim) begin
      st_nxt.div_cnt = 17'h0_0000;
      st_nxt.tick    = 1'b1;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 17'h0_0001;
      st_nxt.tick    = 1'b0;
    end

    if (st_r.tick) begin
      st_nxt.samp = st_r.env_s2;
      if (edge_seen) begin
        st_nxt.gap = 4'h0;
      end else if (st_r.gap != mrd_pkg::GAP_SAT) begin
        st_nxt.gap = st_r.gap + 4'h1;
      end

      case (st_r.state)
        mrd_pkg::MRD_HUNT: begin
          // alternating preamble gives one edge per bit period
          if (edge_seen) begin
            if (is_long) begin
              if (st_r.pre_cnt + 4'h1 >= mrd_pkg::PRE_EDGES) begin
                st_nxt.state   = mrd_pkg::MRD_LOCK;
                st_nxt.pre_cnt = 4'h0;
              end else begin
                st_nxt.pre_cnt = st_r.pre_cnt + 4'h1;
              end
            end else begin
              st_nxt.pre_cnt = 4'h0;
            end
          end else if (st_r.gap == mrd_pkg::GAP_SAT) begin
            st_nxt.pre_cnt = 4'h0;
          end
        end
        mrd_pkg::MRD_LOCK: begin
          // first edge after a quiet frame-start gap is the first mid-bit
          if (edge_seen && st_r.gap == mrd_pkg::GAP_SAT) begin
            st_nxt.state     = mrd_pkg::MRD_FRAME;
            st_nxt.mid_phase = 1'b1;
            emit             = 1'b1;
          end
        end
        mrd_pkg::MRD_FRAME: begin
          if (edge_seen) begin
            if (st_r.mid_phase && is_long) begin
              emit = 1'b1;
            end else if (st_r.mid_phase && is_short) begin
              st_nxt.mid_phase = 1'b0;
            end else if (!st_r.mid_phase && is_short) begin
              st_nxt.mid_phase = 1'b1;
              emit             = 1'b1;
            end else begin
              st_nxt.state = mrd_pkg::MRD_HUNT;
            end
          end else if (ivl > mrd_pkg::LONG_MAX) begin
            // missing mid-bit edge ends the frame
            st_nxt.state = mrd_pkg::MRD_HUNT;
          end
        end
        default: begin
          st_nxt.state = mrd_pkg::MRD_HUNT;
        end
      endcase

      if (!manch_en) begin
        st_nxt.state   = mrd_pkg::MRD_HUNT;
        st_nxt.pre_cnt = 4'h0;
        emit           = 1'b0;
      end

      // strobe stays shorter than the closest mid-bit spacing
      if (emit) begin
        st_nxt.data     = st_r.env_s2;
        st_nxt.strobe   = 1'b1;
        st_nxt.strb_cnt = mrd_pkg::STROBE_TICKS;
      end else if (st_r.strb_cnt > 3'h1) begin
        st_nxt.strb_cnt = st_r.strb_cnt - 3'h1;
      end else begin
        st_nxt.strb_cnt = 3'h0;
        st_nxt.strobe   = 1'b0;
      end
    end
    st_nxt.locked = st_nxt.state != mrd_pkg::MRD_HUNT;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '{
        env_s1:    1'b0,
        env_s2:    1'b0,
        div_cnt:   17'h0_0000,
        tick:      1'b0,
        samp:      1'b0,
        gap:       4'h0,
        mid_phase: 1'b0,
        state:     mrd_pkg::MRD_HUNT,
        pre_cnt:   4'h0,
        data:      1'b0,
        strobe:    1'b0,
        strb_cnt:  3'h0,
        locked:    1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.raw_envelope_out = st_r.samp;
  assign link.decoded_data_out = st_r.data;
  assign link.bit_strobe_out   = st_r.strobe;
  assign locked                = st_r.locked;

endmodule : mrd_decoder

// ### mrd_pkg.sv
// shared constants and types for the manchester receive decoder and its host
package mrd_pkg;

  // ----------------------------------------------------------------------
  // clocking and sample clock range
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned SCLK_MIN_HZ  = 2_500;
  localparam int unsigned SCLK_MAX_HZ  = 50_000;
  localparam int unsigned DIV_W        = 17;
  localparam logic [16:0] DIV_MAX      = 17'(CLK_HZ / SCLK_MIN_HZ);
  localparam logic [16:0] DIV_MIN      = 17'(CLK_HZ / SCLK_MAX_HZ);
  localparam logic [16:0] DIV_RST      = 17'(CLK_HZ / SCLK_MAX_HZ);

  // ----------------------------------------------------------------------
  // samples per bit and interval windows, in sample ticks
  // ----------------------------------------------------------------------
  localparam int unsigned MAN_SPB      = 10;
  localparam int unsigned RAW_SPB      = 5;
  localparam logic [3:0]  LONG_MIN     = 4'h8;
  localparam logic [3:0]  LONG_MAX     = 4'hc;
  localparam logic [3:0]  SHORT_MIN    = 4'h3;
  localparam logic [3:0]  SHORT_MAX    = 4'h7;
  localparam logic [3:0]  GAP_SAT      = 4'hf;
  localparam logic [3:0]  PRE_EDGES    = 4'h8;
  localparam logic [2:0]  STROBE_TICKS = 3'h4;

  // ----------------------------------------------------------------------
  // host side
  // ----------------------------------------------------------------------
  localparam logic [2:0]  BYTE_LAST    = 3'h7;

  typedef enum logic [1:0] {
    MRD_HUNT,
    MRD_LOCK,
    MRD_FRAME
  } mrd_state_t;

endpackage : mrd_pkg

// ### mrd_link_if.sv
// link between the decoder end and the polling host end
`timescale 1ns/1ps
interface mrd_link_if;
  logic envelope_in;
  logic raw_envelope_out;
  logic decoded_data_out;
  logic bit_strobe_out;

  modport dev (
    input  envelope_in,
    output raw_envelope_out,
    output decoded_data_out,
    output bit_strobe_out
  );

  modport host (
    input  raw_envelope_out,
    input  decoded_data_out,
    input  bit_strobe_out
  );
endinterface : mrd_link_if

// ### mrd_host.sv
// host end: polls decoded data on each strobe and packs bytes
`timescale 1ns/1ps
module mrd_host (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       flush,
  mrd_link_if.host        link,
  output logic            rx_bit,
  output logic            rx_bit_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_byte_valid,
  output logic            raw_level
);

  typedef struct packed {
    logic       stb_s1;
    logic       stb_s2;
    logic       stb_s3;
    logic       dat_s1;
    logic       dat_s2;
    logic       raw_s1;
    logic       raw_s2;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic       bit_val;
    logic       bit_vld;
    logic [7:0] byte_val;
    logic       byte_vld;
  } mrd_host_st_t;

  mrd_host_st_t st_r;
  mrd_host_st_t st_nxt;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.stb_s1   = link.bit_strobe_out;
    st_nxt.stb_s2   = st_r.stb_s1;
    st_nxt.stb_s3   = st_r.stb_s2;
    st_nxt.dat_s1   = link.decoded_data_out;
    st_nxt.dat_s2   = st_r.dat_s1;
    st_nxt.raw_s1   = link.raw_envelope_out;
    st_nxt.raw_s2   = st_r.raw_s1;
    st_nxt.bit_vld  = 1'b0;
    st_nxt.byte_vld = 1'b0;
    // data is only trusted on the strobe's rising edge
    if (st_r.stb_s2 && !st_r.stb_s3) begin
      st_nxt.bit_val = st_r.dat_s2;
      st_nxt.bit_vld = 1'b1;
      st_nxt.shift   = {st_r.shift[6:0], st_r.dat_s2};
      if (st_r.bit_cnt == mrd_pkg::BYTE_LAST) begin
        st_nxt.byte_val = {st_r.shift[6:0], st_r.dat_s2};
        st_nxt.byte_vld = 1'b1;
        st_nxt.bit_cnt  = 3'h0;
      end else begin
        st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
      end
    end
    if (flush) begin
      st_nxt.bit_cnt = 3'h0;
      st_nxt.shift   = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rx_bit        = st_r.bit_val;
  assign rx_bit_valid  = st_r.bit_vld;
  assign rx_byte       = st_r.byte_val;
  assign rx_byte_valid = st_r.byte_vld;
  assign raw_level     = st_r.raw_s2;

endmodule : mrd_host

// ### mrd_link_properties.sv
// assertions on the link between the decoder end and the host end
`timescale 1ns/1ps
module mrd_link_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic envelope_in,
  input wire logic raw_envelope_out,
  input wire logic decoded_data_out,
  input wire logic bit_strobe_out
);
  // bench runs the divider at its floor, so one tick is this many clk
  localparam int unsigned TICK_CLK = 5000;

  // ----------------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------------
  logic [19:0] high_r;
  logic [19:0] since_r;
  logic [15:0] skew_r;
  logic        strobe_q_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      high_r     <= 20'h0_0000;
      since_r    <= 20'hf_ffff;
      skew_r     <= 16'h0000;
      strobe_q_r <= 1'b0;
    end else begin
      strobe_q_r <= bit_strobe_out;
      high_r     <= bit_strobe_out ? high_r + 20'h0_0001 : 20'h0_0000;
      since_r    <= (bit_strobe_out && !strobe_q_r) ? 20'h0_0000 : since_r + 20'(since_r != 20'hf_ffff);
      skew_r     <= (raw_envelope_out != envelope_in) ? skew_r + 16'h0001 : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking

  property p_reset_quiet;
    !rstn |=> !bit_strobe_out && !decoded_data_out && !raw_envelope_out;
  endproperty
  property p_strobe_width;
    disable iff (!rstn) $fell(bit_strobe_out) |-> high_r == 20'(4 * TICK_CLK);
  endproperty
  property p_strobe_hold;
    disable iff (!rstn) $rose(bit_strobe_out) |=> bit_strobe_out[*8];
  endproperty
  property p_data_at_rise;
    disable iff (!rstn) $changed(decoded_data_out) |-> $rose(bit_strobe_out);
  endproperty
  property p_bit_value;
    disable iff (!rstn) $rose(bit_strobe_out) |-> decoded_data_out == raw_envelope_out;
  endproperty
  property p_strobe_spacing;
    disable iff (!rstn) $rose(bit_strobe_out) |-> since_r >= 20'(6 * TICK_CLK - 1);
  endproperty
  property p_raw_follows;
    disable iff (!rstn) skew_r <= 16'(TICK_CLK + 4);
  endproperty
  property p_raw_per_tick;
    disable iff (!rstn) $changed(raw_envelope_out) |=> $stable(raw_envelope_out)[*8];
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("link output active in reset");
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width off");
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe too short");
  a_data_at_rise: assert property (p_data_at_rise) else $error("data moved between bits");
  a_bit_value: assert property (p_bit_value) else $error("bit value not level after mid edge");
  a_strobe_spacing: assert property (p_strobe_spacing) else $error("strobes too close");
  a_raw_follows: assert property (p_raw_follows) else $error("raw output lags envelope");
  a_raw_per_tick: assert property (p_raw_per_tick) else $error("raw changed off tick");

  c_strobe_rise: cover property ($rose(bit_strobe_out));
  c_strobe_fall: cover property ($fell(bit_strobe_out));
  c_raw_rise: cover property ($rose(raw_envelope_out));
endmodule : mrd_link_properties

// ### manchester_rx_decoder_bench.sv
// testbench joining decoder and host, driving envelope frames
`timescale 1ns/1ps
module manchester_rx_decoder_bench;
  // one half bit is five ticks of 5000 clk
  localparam int unsigned  HALF      = 25000;
  localparam logic [7:0]   BYTE_SENT = 8'h5a;
  // transmitter fast by about sixteen percent, the combined worst case of both ends
  localparam int unsigned  HALF_FAST = 21600;
  localparam logic [7:0]   BYTE_FAST = 8'hc3;
  int          half_len;
  int          n_bits;
  logic        clk;
  logic        rstn;
  logic [16:0] sclk_div;
  logic        manch_en;
  logic        flush;
  logic        locked;
  logic        rx_bit;
  logic        rx_bit_valid;
  logic [7:0]  rx_byte;
  logic        rx_byte_valid;
  logic        raw_level;
  logic [7:0]  got_byte;
  int          n_strobes;
  int          n_errors;
  int          checks_done;

  mrd_link_if mrd_link_if_inst ();
  mrd_decoder mrd_decoder_inst (.clk(clk), .rstn(rstn), .sclk_div(sclk_div), .manch_en(manch_en),
    .locked(locked), .link(mrd_link_if_inst.dev));
  mrd_host mrd_host_inst (.clk(clk), .rstn(rstn), .flush(flush), .link(mrd_link_if_inst.host),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .raw_level(raw_level));
  mrd_link_properties mrd_link_properties_inst (.clk(clk), .rstn(rstn),
    .envelope_in(mrd_link_if_inst.envelope_in), .raw_envelope_out(mrd_link_if_inst.raw_envelope_out),
    .decoded_data_out(mrd_link_if_inst.decoded_data_out), .bit_strobe_out(mrd_link_if_inst.bit_strobe_out));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rx_byte_valid === 1'b1) got_byte <= rx_byte;
  end
  always @(posedge mrd_link_if_inst.bit_strobe_out) n_strobes++;
  always @(posedge clk) begin
    if (rx_bit_valid === 1'b1) n_bits++;
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_val

  task automatic check_count(input string what, input int exp, input int seen);
    checks_done++;
    if (seen != exp) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check_count

  task automatic hold(input logic level);
    @(negedge clk);
    mrd_link_if_inst.envelope_in = level;
    repeat (half_len - 1) @(negedge clk);
  endtask : hold

  // rising mid edge carries a one
  task automatic send_bit(input logic b);
    hold(~b);
    hold(b);
  endtask : send_bit

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (1_700_000) @(posedge clk);
    n_errors++;
    $display("timeout");
    complete_run();
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    n_strobes = 0;
    n_bits = 0;
    half_len = HALF;
    got_byte = 8'h00;
    rstn = 1'b0;
    sclk_div = 17'h0_1388;
    manch_en = 1'b0;
    flush = 1'b1;
    mrd_link_if_inst.envelope_in = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    flush = 1'b0;
    hold(1'b1);
    check_val("raw_envelope_out", 8'h01, {7'h00, mrd_link_if_inst.raw_envelope_out});
    check_val("raw_level", 8'h01, {7'h00, raw_level});
    hold(1'b0);
    check_val("raw_envelope_out", 8'h00, {7'h00, mrd_link_if_inst.raw_envelope_out});
    check_val("locked", 8'h00, {7'h00, locked});
    check_count("strobes", 0, n_strobes);
    $display("test raw pass done");
    manch_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      send_bit(1'b0);
      send_bit(1'b1);
    end
    check_val("locked", 8'h01, {7'h00, locked});
    // quiet gap marks frame start, first data bit must begin high
    for (int i = 0; i < 4; i++) hold(1'b1);
    check_count("strobes", 0, n_strobes);
    for (int i = 7; i >= 0; i--) send_bit(BYTE_SENT[i]);
    check_val("rx_byte", BYTE_SENT, got_byte);
    check_val("rx_bit", 8'h00, {7'h00, rx_bit});
    check_val("decoded_data_out", 8'h00, {7'h00, mrd_link_if_inst.decoded_data_out});
    check_count("strobes", 8, n_strobes);
    check_count("rx_bit_valid pulses", 8, n_bits);
    $display("test frame done");
    // same frame goes on at the drifted rate; a setting below the floor must be clamped
    half_len = HALF_FAST;
    sclk_div = 17'h0_0010;
    for (int i = 7; i >= 0; i--) send_bit(BYTE_FAST[i]);
    check_val("rx_byte", BYTE_FAST, got_byte);
    check_val("rx_bit", 8'h01, {7'h00, rx_bit});
    check_val("decoded_data_out", 8'h01, {7'h00, mrd_link_if_inst.decoded_data_out});
    check_count("strobes", 16, n_strobes);
    check_count("rx_bit_valid pulses", 16, n_bits);
    $display("test drift done");
    for (int i = 0; i < 4; i++) hold(1'b0);
    check_val("locked", 8'h00, {7'h00, locked});
    check_count("strobes", 16, n_strobes);
    $display("test drop out done");
    complete_run();
  end
endmodule : manchester_rx_decoder_bench
